// *** ctcm_pkg.sv ***
// Shared constants for the dual counter/timer block: register map, fields, reset values and encodings.
package ctcm_pkg;

	// Instance and channel counts.
	localparam int CTCM_NUM_INST  = 2;
	localparam int CTCM_NUM_MATCH = 4;
	localparam int CTCM_NUM_CAP   = 2;
	localparam int CTCM_NUM_EXT   = 2;
	localparam int CTCM_DW        = 32;

	// Byte offsets inside one instance window; instance n sits at n * stride.
	localparam logic [11:0] CTCM_INST_STRIDE   = 12'h040;
	localparam logic [11:0] CTCM_OFF_CTRL      = 12'h000;
	localparam logic [11:0] CTCM_OFF_COUNT     = 12'h004;
	localparam logic [11:0] CTCM_OFF_PRE_LIMIT = 12'h008;
	localparam logic [11:0] CTCM_OFF_PRE_COUNT = 12'h00C;
	localparam logic [11:0] CTCM_OFF_MATCH_CTL = 12'h010;
	localparam logic [11:0] CTCM_OFF_CAP_CTL   = 12'h014;
	localparam logic [11:0] CTCM_OFF_EXT_MATCH = 12'h018;
	localparam logic [11:0] CTCM_OFF_MATCH0    = 12'h020;
	localparam logic [11:0] CTCM_OFF_CAP0      = 12'h030;

	// Shared interrupt registers after both instance windows.
	localparam logic [11:0] CTCM_OFF_INT_STAT  = 12'h080;
	localparam logic [11:0] CTCM_OFF_INT_MASK  = 12'h084;

	// Control register fields.
	localparam int CTCM_CTRL_EN   = 0;
	localparam int CTCM_CTRL_HOLD = 1;
	localparam int CTCM_CTRL_MODE = 2;
	localparam int CTCM_CTRL_SRC  = 3;
	localparam int CTCM_CTRL_EDGE = 4;

	// Match control: three bits per match register.
	localparam int CTCM_MC_STRIDE = 3;
	localparam int CTCM_MC_INT    = 0;
	localparam int CTCM_MC_RST    = 1;
	localparam int CTCM_MC_STOP   = 2;

	// Capture control: three bits per channel, then the clear-on-capture fields.
	localparam int CTCM_CC_STRIDE   = 3;
	localparam int CTCM_CC_RISE     = 0;
	localparam int CTCM_CC_FALL     = 1;
	localparam int CTCM_CC_INT      = 2;
	localparam int CTCM_CC_CLR_EN   = 8;
	localparam int CTCM_CC_CLR_CH   = 9;
	localparam int CTCM_CC_CLR_FALL = 10;

	// External match: two action bits per output, current pin levels read back from bit 8.
	localparam int CTCM_EM_STATE = 8;

	// Interrupt status layout: eight bits per instance, captures above the matches.
	localparam int CTCM_INT_STRIDE   = 8;
	localparam int CTCM_INT_CAP_BASE = 4;
	localparam int CTCM_INT_W        = 16;

	// Writable bits and reset values.
	localparam logic [31:0] CTCM_CTRL_MASK = 32'h0000_003F;
	localparam logic [31:0] CTCM_MC_MASK   = 32'h0000_0FFF;
	localparam logic [31:0] CTCM_CC_MASK   = 32'h0000_073F;
	localparam logic [31:0] CTCM_EM_MASK   = 32'h0000_000F;
	localparam logic [31:0] CTCM_RST_REG   = 32'h0000_0000;

	// Action taken on an external match output.
	typedef enum logic [1:0] {
		CTCM_ACT_NONE   = 2'b00,
		CTCM_ACT_LOW    = 2'b01,
		CTCM_ACT_HIGH   = 2'b10,
		CTCM_ACT_TOGGLE = 2'b11
	} ctcm_act_e;

endpackage

// *** ctcm_core.sv ***
// One counter/timer instance: prescaler, count, capture channels, match actions and match outputs.
`timescale 1ns/10ps
module ctcm_core #(
	parameter int CW = 32
) (
	// Clock and reset.
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	// Configuration from the register file.
	input  wire logic                                   en,
	input  wire logic                                   hold,
	input  wire logic                                   cnt_mode,
	input  wire logic                                   cnt_src,
	input  wire logic [1:0]                             cnt_edge,
	input  wire logic [CW-1:0]                          pre_limit,
	input  wire logic [ctcm_pkg::CTCM_NUM_MATCH-1:0][CW-1:0] match_val,
	input  wire logic [ctcm_pkg::CTCM_NUM_MATCH-1:0]    match_rst,
	input  wire logic [ctcm_pkg::CTCM_NUM_MATCH-1:0]    match_stop,
	input  wire logic [ctcm_pkg::CTCM_NUM_EXT-1:0][1:0] ext_act,
	input  wire logic [ctcm_pkg::CTCM_NUM_CAP-1:0]      cap_rise,
	input  wire logic [ctcm_pkg::CTCM_NUM_CAP-1:0]      cap_fall,
	input  wire logic                                   clr_en,
	input  wire logic                                   clr_ch,
	input  wire logic                                   clr_fall,
	// Software load of the count.
	input  wire logic                                   ld_cnt,
	input  wire logic [CW-1:0]                          ld_val,
	// Filtered capture input levels.
	input  wire logic [ctcm_pkg::CTCM_NUM_CAP-1:0]      cap_lvl,
	// State and events.
	output logic      [CW-1:0]                          count_value,
	output logic      [CW-1:0]                          pre_count,
	output logic      [ctcm_pkg::CTCM_NUM_CAP-1:0][CW-1:0] cap_val,
	output logic      [ctcm_pkg::CTCM_NUM_MATCH-1:0]    match_evt,
	output logic      [ctcm_pkg::CTCM_NUM_CAP-1:0]      cap_evt,
	output logic                                        stop_req,
	output logic      [ctcm_pkg::CTCM_NUM_EXT-1:0]      ext_out,
	output logic      [1:0]                             dma_req
);
	import ctcm_pkg::*;

	logic [CW-1:0]              count_ff;
	logic [CW-1:0]              nxt_count;
	logic [CW-1:0]              pcount_ff;
	logic [CW-1:0]              nxt_pcount;
	logic [CTCM_NUM_CAP-1:0]    lvl_prev_ff;
	logic [CTCM_NUM_CAP-1:0]    rise;
	logic [CTCM_NUM_CAP-1:0]    fall;
	logic [CTCM_NUM_EXT-1:0]    ext_ff;
	logic [CTCM_NUM_EXT-1:0]    nxt_ext;
	logic [1:0]                 dma_ff;
	logic                       run;
	logic                       cnt_tick;
	logic                       pre_wrap;
	logic                       any_rst;
	logic                       clr_evt;

	// Edge detection on the already filtered capture levels.
	assign rise = cap_lvl & ~lvl_prev_ff;
	assign fall = ~cap_lvl & lvl_prev_ff;

	// Timer mode ticks every bus clock; counter mode ticks on chosen edges of one capture input.
	assign run      = en & ~hold;
	assign cnt_tick = run & (cnt_mode ? ((cnt_edge[0] & rise[cnt_src]) | (cnt_edge[1] & fall[cnt_src])) : 1'b1); // [R2]
	assign pre_wrap = cnt_tick & (pcount_ff == pre_limit); // [R9]

	// A match fires when the count advances away from a value equal to a match register.
	genvar gm;
	generate
		for (gm = 0; gm < CTCM_NUM_MATCH; gm++) begin : g_match
			assign match_evt[gm] = pre_wrap & (count_ff == match_val[gm]); // [R6]
		end
	endgenerate
	assign any_rst  = |(match_evt & match_rst); // [R6]
	assign stop_req = |(match_evt & match_stop); // [R6]

	// Capture edges and the optional clearing edge.
	assign cap_evt = (rise & cap_rise) | (fall & cap_fall); // [R3]
	assign clr_evt = clr_en & (clr_fall ? fall[clr_ch] : rise[clr_ch]); // [R5]

	// Next count: clear and hold win over a software load, which wins over counting.
	always_comb begin
		nxt_count  = count_ff;
		nxt_pcount = pcount_ff;
		if (hold || clr_evt) begin
			nxt_count  = '0; // [R5]
			nxt_pcount = '0;
		end else if (ld_cnt) begin
			nxt_count  = ld_val;
			nxt_pcount = '0;
		end else if (pre_wrap) begin
			nxt_pcount = '0; // [R9]
			nxt_count  = any_rst ? '0 : count_ff + 1'b1; // [R1]
		end else if (cnt_tick) begin
			nxt_pcount = pcount_ff + 1'b1; // [R9]
		end
	end

	// Count, prescaler and edge history.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff    <= '0;
			pcount_ff   <= '0;
			lvl_prev_ff <= '0;
			dma_ff      <= '0;
		end else begin
			count_ff    <= nxt_count;
			pcount_ff   <= nxt_pcount;
			lvl_prev_ff <= cap_lvl;
			dma_ff      <= match_evt[1:0]; // [R8]
		end
	end

	// Each capture channel snapshots the count present when its edge arrives.
	genvar gc;
	generate
		for (gc = 0; gc < CTCM_NUM_CAP; gc++) begin : g_cap
			logic [CW-1:0] cap_ff;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_ff <= '0;
				end else if (cap_evt[gc]) begin
					cap_ff <= count_ff; // [R3] [R4]
				end
			end
			assign cap_val[gc] = cap_ff;
		end
	endgenerate

	// Match outputs follow the action of their own match register.
	genvar ge;
	generate
		for (ge = 0; ge < CTCM_NUM_EXT; ge++) begin : g_ext
			assign nxt_ext[ge] = !match_evt[ge]                  ? ext_ff[ge] :
			                     (ext_act[ge] == CTCM_ACT_LOW)    ? 1'b0 :
			                     (ext_act[ge] == CTCM_ACT_HIGH)   ? 1'b1 :
			                     (ext_act[ge] == CTCM_ACT_TOGGLE) ? ~ext_ff[ge] : ext_ff[ge]; // [R7]
		end
	endgenerate

	// Output levels live in flip-flops so the pins never glitch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_ff <= '0;
		end else begin
			ext_ff <= nxt_ext;
		end
	end

	assign count_value = count_ff;
	assign pre_count   = pcount_ff;
	assign ext_out     = ext_ff;
	assign dma_req     = dma_ff;

endmodule

// *** ctcm_top.sv ***
// Dual counter/timer with APB register file, capture pin filters, match pins, DMA triggers and interrupt.
//
// Contract
// R1 - Two independent counter/timers each have a 32-bit count advanced through a programmable 32-bit prescaler.
// R2 - Timer mode counts bus clocks while counter mode counts edges of a selected capture input instead.
// R3 - Each instance has up to two 32-bit capture channels storing the count on an input edge, optionally interrupting.
// R4 - Each capture signal comes from its own capture pin and feeds exactly one capture channel of its timer.
// R5 - A chosen capture edge can clear both count and prescaler, enabling pulse-width measurement.
// R6 - Four 32-bit match registers per instance can continue, stop or reset the timer, each optionally interrupting.
// R7 - Up to two match outputs per instance go low, high, toggle or stay unchanged on their match.
// R8 - Two match registers per instance raise DMA requests on their match events.
// R9 - The prescaler counts input edges and advances the count each time it reaches its limit, then restarts at zero.
// R10 - Each match and capture event sets its own flag, cleared by writing one, with the interrupt high while an enabled flag is set.
//       The code sets a flag only for an event whose interrupt option is on, and a read of the status also clears the flags it returns.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
module ctcm_top (
	// Clock and reset.
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave.
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Capture pins, two per instance.
	input  wire logic [ctcm_pkg::CTCM_NUM_INST*ctcm_pkg::CTCM_NUM_CAP-1:0] cap_pin,
	// Match pins, two per instance.
	output logic      [ctcm_pkg::CTCM_NUM_INST*ctcm_pkg::CTCM_NUM_EXT-1:0] match_pin,
	// DMA triggers, two per instance.
	output logic      [ctcm_pkg::CTCM_NUM_INST*2-1:0]                      dma_req,
	// Interrupt.
	output logic                               irq
);
	import ctcm_pkg::*;

	localparam int NPIN = CTCM_NUM_INST * CTCM_NUM_CAP;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode.

	logic                         wr_acc;
	logic                         rd_acc;
	logic                         setup;
	logic [5:0]                   loc_off;
	logic                         inst_win;
	logic                         inst_idx;
	logic                         com_win;
	logic                         stat_hit;
	logic                         mask_hit;
	logic [CTCM_NUM_INST-1:0]     inst_hit;
	logic [CTCM_NUM_INST-1:0]     inst_ok;
	logic [31:0]                  inst_rd [CTCM_NUM_INST];
	logic                         addr_ok;
	logic [31:0]                  rd_mux;
	logic [31:0]                  prdata_ff;

	// Writes and read-clears take effect only on the access edge; pready is always high.
	assign setup    = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign loc_off  = paddr[5:0];
	assign inst_win = (paddr[11:7] == 5'd0);
	assign inst_idx = paddr[6];
	assign com_win  = (paddr[11:7] == CTCM_OFF_INT_STAT[11:7]);
	assign stat_hit = com_win & (paddr[6:0] == CTCM_OFF_INT_STAT[6:0]);
	assign mask_hit = com_win & (paddr[6:0] == CTCM_OFF_INT_MASK[6:0]);

	////////////////////////////////////////////////////////////////////////////////
	// Capture pin filters.

	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic [NPIN-1:0] sync3_ff;
	logic [NPIN-1:0] lvl_ff;

	// Three stages; the filtered level moves only once the second and third stages agree,
	// which rejects a single-cycle glitch at the cost of two extra cycles of latency.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			lvl_ff   <= '0;
		end else begin
			sync1_ff <= cap_pin;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			lvl_ff   <= (sync2_ff & sync3_ff) | (lvl_ff & (sync2_ff | sync3_ff)); // [R4]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-instance registers and timer cores.

	logic [CTCM_INT_W-1:0] flag_set;

	genvar gi;
	genvar gm;
	generate
		for (gi = 0; gi < CTCM_NUM_INST; gi++) begin : g_inst
			logic [31:0]                                ctrl_ff;
			logic [31:0]                                pre_ff;
			logic [31:0]                                mctl_ff;
			logic [31:0]                                cctl_ff;
			logic [31:0]                                ext_ff;
			logic [CTCM_NUM_MATCH-1:0][31:0]            match_ff;
			logic [CTCM_NUM_MATCH-1:0]                  m_int;
			logic [CTCM_NUM_MATCH-1:0]                  m_rst;
			logic [CTCM_NUM_MATCH-1:0]                  m_stop;
			logic [CTCM_NUM_EXT-1:0][1:0]               e_act;
			logic [CTCM_NUM_CAP-1:0]                    c_rise;
			logic [CTCM_NUM_CAP-1:0]                    c_fall;
			logic [CTCM_NUM_CAP-1:0]                    c_int;
			logic [31:0]                                cnt_w;
			logic [31:0]                                pcnt_w;
			logic [CTCM_NUM_CAP-1:0][31:0]              cap_w;
			logic [CTCM_NUM_MATCH-1:0]                  mevt_w;
			logic [CTCM_NUM_CAP-1:0]                    cevt_w;
			logic [CTCM_NUM_EXT-1:0]                    ext_w;
			logic                                       stop_w;
			logic                                       wr_me;
			logic                                       ld_cnt;
			logic                                       rd_hit;

			assign inst_hit[gi] = inst_win & (inst_idx == gi[0]);
			assign wr_me        = wr_acc & inst_hit[gi];
			assign ld_cnt       = wr_me & (loc_off == CTCM_OFF_COUNT[5:0]);

			// Unpack the per-match and per-channel control fields.
			for (gm = 0; gm < CTCM_NUM_MATCH; gm++) begin : g_mf
				assign m_int[gm]  = mctl_ff[gm*CTCM_MC_STRIDE + CTCM_MC_INT];
				assign m_rst[gm]  = mctl_ff[gm*CTCM_MC_STRIDE + CTCM_MC_RST];
				assign m_stop[gm] = mctl_ff[gm*CTCM_MC_STRIDE + CTCM_MC_STOP];
			end
			for (gm = 0; gm < CTCM_NUM_CAP; gm++) begin : g_cf
				assign c_rise[gm] = cctl_ff[gm*CTCM_CC_STRIDE + CTCM_CC_RISE];
				assign c_fall[gm] = cctl_ff[gm*CTCM_CC_STRIDE + CTCM_CC_FALL];
				assign c_int[gm]  = cctl_ff[gm*CTCM_CC_STRIDE + CTCM_CC_INT];
			end
			for (gm = 0; gm < CTCM_NUM_EXT; gm++) begin : g_ef
				assign e_act[gm] = ext_ff[2*gm +: 2];
			end

			// Control: a stop-on-match clears the enable unless software writes it in the same cycle.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_ff <= CTCM_RST_REG;
				end else if (wr_me && loc_off == CTCM_OFF_CTRL[5:0]) begin
					ctrl_ff <= pwdata & CTCM_CTRL_MASK;
				end else if (stop_w) begin
					ctrl_ff[CTCM_CTRL_EN] <= 1'b0; // [R6]
				end
			end

			// Prescale limit and the three control words.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pre_ff  <= CTCM_RST_REG;
					mctl_ff <= CTCM_RST_REG;
					cctl_ff <= CTCM_RST_REG;
					ext_ff  <= CTCM_RST_REG;
				end else if (wr_me) begin
					if (loc_off == CTCM_OFF_PRE_LIMIT[5:0]) pre_ff <= pwdata; // [R1]
					if (loc_off == CTCM_OFF_MATCH_CTL[5:0]) mctl_ff <= pwdata & CTCM_MC_MASK;
					if (loc_off == CTCM_OFF_CAP_CTL[5:0]) cctl_ff <= pwdata & CTCM_CC_MASK;
					if (loc_off == CTCM_OFF_EXT_MATCH[5:0]) ext_ff <= pwdata & CTCM_EM_MASK;
				end
			end

			// Match value registers.
			for (gm = 0; gm < CTCM_NUM_MATCH; gm++) begin : g_mreg
				localparam logic [5:0] MOFF = 6'(CTCM_OFF_MATCH0[5:0] + 6'(4 * gm));
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						match_ff[gm] <= CTCM_RST_REG;
					end else if (wr_me && loc_off == MOFF) begin
						match_ff[gm] <= pwdata; // [R6]
					end
				end
			end

			ctcm_core #(
				.CW (CTCM_DW)
			) u_core (
				.pclk        (pclk),
				.presetn     (presetn),
				.en          (ctrl_ff[CTCM_CTRL_EN]),
				.hold        (ctrl_ff[CTCM_CTRL_HOLD]),
				.cnt_mode    (ctrl_ff[CTCM_CTRL_MODE]),
				.cnt_src     (ctrl_ff[CTCM_CTRL_SRC]),
				.cnt_edge    (ctrl_ff[CTCM_CTRL_EDGE +: 2]),
				.pre_limit   (pre_ff),
				.match_val   (match_ff),
				.match_rst   (m_rst),
				.match_stop  (m_stop),
				.ext_act     (e_act),
				.cap_rise    (c_rise),
				.cap_fall    (c_fall),
				.clr_en      (cctl_ff[CTCM_CC_CLR_EN]),
				.clr_ch      (cctl_ff[CTCM_CC_CLR_CH]),
				.clr_fall    (cctl_ff[CTCM_CC_CLR_FALL]),
				.ld_cnt      (ld_cnt),
				.ld_val      (pwdata),
				.cap_lvl     (lvl_ff[gi*CTCM_NUM_CAP +: CTCM_NUM_CAP]), // [R4]
				.count_value (cnt_w),
				.pre_count   (pcnt_w),
				.cap_val     (cap_w),
				.match_evt   (mevt_w),
				.cap_evt     (cevt_w),
				.stop_req    (stop_w),
				.ext_out     (ext_w),
				.dma_req     (dma_req[gi*2 +: 2]) // [R8]
			);

			assign match_pin[gi*CTCM_NUM_EXT +: CTCM_NUM_EXT] = ext_w; // [R7]

			// Events whose interrupt option is on raise their status flag.
			assign flag_set[gi*CTCM_INT_STRIDE +: CTCM_NUM_MATCH] = mevt_w & m_int; // [R6] [R10]
			assign flag_set[gi*CTCM_INT_STRIDE + CTCM_INT_CAP_BASE +: CTCM_NUM_CAP] = cevt_w & c_int; // [R3] [R10]
			assign flag_set[gi*CTCM_INT_STRIDE + CTCM_INT_CAP_BASE + CTCM_NUM_CAP +: 2] = 2'b00;

			// Read view of this instance; holes in the window answer with an error.
			always_comb begin
				inst_rd[gi] = 32'h0000_0000;
				rd_hit      = 1'b1;
				case (loc_off)
					CTCM_OFF_CTRL[5:0]:      inst_rd[gi] = ctrl_ff;
					CTCM_OFF_COUNT[5:0]:     inst_rd[gi] = cnt_w;
					CTCM_OFF_PRE_LIMIT[5:0]: inst_rd[gi] = pre_ff;
					CTCM_OFF_PRE_COUNT[5:0]: inst_rd[gi] = pcnt_w;
					CTCM_OFF_MATCH_CTL[5:0]: inst_rd[gi] = mctl_ff;
					CTCM_OFF_CAP_CTL[5:0]:   inst_rd[gi] = cctl_ff;
					CTCM_OFF_EXT_MATCH[5:0]: inst_rd[gi] = ext_ff | (32'(ext_w) << CTCM_EM_STATE);
					6'h20:                   inst_rd[gi] = match_ff[0];
					6'h24:                   inst_rd[gi] = match_ff[1];
					6'h28:                   inst_rd[gi] = match_ff[2];
					6'h2C:                   inst_rd[gi] = match_ff[3];
					CTCM_OFF_CAP0[5:0]:      inst_rd[gi] = cap_w[0];
					6'h34:                   inst_rd[gi] = cap_w[1];
					default:                 rd_hit      = 1'b0;
				endcase
			end
			assign inst_ok[gi] = inst_hit[gi] & rd_hit;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask.

	logic [CTCM_INT_W-1:0] stat_ff;
	logic [CTCM_INT_W-1:0] nxt_stat;
	logic [CTCM_INT_W-1:0] mask_ff;
	logic [CTCM_INT_W-1:0] stat_clr;

	// A read clears only the bits it returned, and a one written clears too; a new event wins over either.
	assign stat_clr = ((wr_acc & stat_hit) ? pwdata[CTCM_INT_W-1:0] : '0) |
	                  ((rd_acc & stat_hit) ? prdata_ff[CTCM_INT_W-1:0] : '0); // [R10]
	assign nxt_stat = (stat_ff & ~stat_clr) | flag_set; // [R10]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= '0;
			mask_ff <= '0;
		end else begin
			stat_ff <= nxt_stat;
			if (wr_acc && mask_hit) begin
				mask_ff <= pwdata[CTCM_INT_W-1:0];
			end
		end
	end

	assign irq = |(stat_ff & mask_ff); // [R10]

	////////////////////////////////////////////////////////////////////////////////
	// Read data and bus answer.

	assign addr_ok = (|inst_ok) | stat_hit | mask_hit;
	assign rd_mux  = inst_ok[0] ? inst_rd[0] :
	                 inst_ok[1] ? inst_rd[1] :
	                 stat_hit   ? {16'h0000, stat_ff} :
	                 mask_hit   ? {16'h0000, mask_ff} : 32'h0000_0000;

	// Read data is sampled in the setup cycle, so it stands still through the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			prdata_ff <= rd_mux;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

endmodule

// *** ctcm_assertions.sv ***
// Port-level checks on the dual counter/timer, bound into its top module.
`timescale 1ns/10ps
module ctcm_assertions
	import ctcm_pkg::*;
(
	// Clock, reset and bus.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and interrupt.
	input wire logic [3:0]  match_pin,
	input wire logic [3:0]  dma_req,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase; an error outside it would stall a master that samples late.
	wire acc = psel && penable;
	AST_READY: assert property (pready) else $error("pready low");
	AST_ERR_PHASE: assert property (pslverr |-> acc) else $error("error outside access");
	AST_ERR_DATA: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_MAPPED: assert property (acc && paddr == CTCM_OFF_CTRL |-> !pslverr) else $error("mapped error");
	AST_RDATA: assert property (acc |=> $stable(prdata)) else $error("read data moved");
	AST_MASK: assert property (acc && pwrite && paddr == CTCM_OFF_INT_MASK && pwdata == 32'h0000_0000 |=> !irq)
		else $error("irq with empty mask");
	AST_PIN_DMA: assert property (((match_pin ^ $past(match_pin)) & ~dma_req) == 4'h0)
		else $error("pin moved without match");
	AST_IRQ_RST: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ctcm_top ctcm_assertions ctcm_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .match_pin(match_pin), .dma_req(dma_req), .irq(irq));

// *** ctcm_pins.sv ***
// External signal sources on the capture pins, and a counter of match output toggles.
`timescale 1ns/10ps
module ctcm_pins (
	// Clock, wanted levels and match outputs.
	input  wire logic        pclk,
	input  wire logic [3:0]  want,
	input  wire logic [3:0]  match_pin,
	// Capture pins and toggles seen.
	output logic      [3:0]  cap_pin,
	output logic      [31:0] edges
);
	logic [3:0] last_pin;
	initial cap_pin = 4'h0;
	initial edges = 32'h0000_0000;
	initial last_pin = 4'h0;
	// One source per capture pin; steps land on the clock so no edge is lost.
	// Changes of the first match output of instance zero are counted one edge late.
	always @(posedge pclk) begin
		cap_pin <= want;
		last_pin <= match_pin;
		edges <= edges + {31'h0000_0000, match_pin[0] ^ last_pin[0]};
	end
endmodule

// *** ctcm_test.sv ***
// Self-checking bench for the dual counter/timer.
`timescale 1ns/10ps
module ctcm_test;
	import ctcm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, tog;
	logic [3:0]  cap_pin, match_pin, dma_req, want;
	int          bad_count, num_checks, dmas;
	ctcm_top ctcm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cap_pin(cap_pin), .match_pin(match_pin), .dma_req(dma_req), .irq(irq));
	ctcm_pins ctcm_pins_inst (.pclk(pclk), .want(want), .match_pin(match_pin), .cap_pin(cap_pin), .edges(tog));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// DMA pulses of the first match of instance zero.
	always @(posedge pclk) begin
		if (dma_req[0] === 1'b1) dmas <= dmas + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One bus transfer; the idle cycle after it keeps strobes from being driven twice at one edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0000_0000, irq}, 32'h0000_0001);
	endtask
	// Slow pin pulses, wide enough for the input filter.
	task automatic pulse;
		want <= 4'h0;
		repeat (8) @(posedge pclk);
		want <= 4'h1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#400000;
		bad_count++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
		{bad_count, num_checks, dmas} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTCM_OFF_CTRL, CTCM_RST_REG);
		rd(12'h01C, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		// Prescaled timer, reset on match, toggled pin, DMA and interrupt.
		apb(1'b1, CTCM_OFF_PRE_LIMIT, 32'h0000_0001);
		apb(1'b1, CTCM_OFF_MATCH0, 32'h0000_0003);
		apb(1'b1, CTCM_OFF_MATCH_CTL, 32'h0000_0003);
		apb(1'b1, CTCM_OFF_EXT_MATCH, 32'h0000_000B);
		apb(1'b1, CTCM_OFF_INT_MASK, 32'h0000_0011);
		apb(1'b1, CTCM_OFF_CTRL, 32'h0000_0001);
		wait_irq();
		apb(1'b1, CTCM_OFF_CTRL, 32'h0000_0000);
		chk({30'h0000_0000, match_pin[1:0]}, 32'h0000_0003);
		chk(tog, 32'h0000_0001);
		rd(CTCM_OFF_EXT_MATCH, 32'h0000_030B);
		chk(dmas, 32'h0000_0001);
		rd(CTCM_OFF_INT_STAT, 32'h0000_0001);
		rd(CTCM_OFF_INT_STAT, 32'h0000_0000);
		// Second instance stops on its match; the wrap still lands.
		apb(1'b1, CTCM_INST_STRIDE + CTCM_OFF_MATCH0, 32'h0000_0002);
		apb(1'b1, CTCM_INST_STRIDE + CTCM_OFF_MATCH_CTL, 32'h0000_0004);
		apb(1'b1, CTCM_INST_STRIDE + CTCM_OFF_CTRL, 32'h0000_0001);
		repeat (12) @(posedge pclk);
		rd(CTCM_INST_STRIDE + CTCM_OFF_CTRL, 32'h0000_0000);
		rd(CTCM_INST_STRIDE + CTCM_OFF_COUNT, 32'h0000_0003);
		rd(CTCM_OFF_INT_STAT, 32'h0000_0000);
		// Capture of a loaded count on a rising pin, then clearing by a write of one.
		apb(1'b1, CTCM_OFF_COUNT, 32'h0000_1234);
		apb(1'b1, CTCM_OFF_CAP_CTL, 32'h0000_0005);
		want <= 4'h1;
		wait_irq();
		rd(CTCM_OFF_CAP0, 32'h0000_1234);
		apb(1'b1, CTCM_OFF_INT_STAT, 32'h0000_0010);
		rd(CTCM_OFF_INT_STAT, 32'h0000_0000);
		// Clear on capture edge, then counter mode through the prescaler.
		apb(1'b1, CTCM_OFF_CAP_CTL, 32'h0000_0100);
		pulse();
		rd(CTCM_OFF_COUNT, 32'h0000_0000);
		apb(1'b1, CTCM_OFF_CAP_CTL, 32'h0000_0000);
		apb(1'b1, CTCM_OFF_CTRL, 32'h0000_0015);
		repeat (4) pulse();
		rd(CTCM_OFF_COUNT, 32'h0000_0002);
		rd(CTCM_OFF_PRE_COUNT, 32'h0000_0000);
		apb(1'b1, CTCM_OFF_INT_MASK, 32'h0000_0000);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		conclude();
	end
endmodule
